// file: core/emspm_mapper.sv
// Expanded-memory page mapper: register file and address translator.
// Assumes AXI4-Lite master, synchronous processor address, delay probes supplied.
`timescale 1ns/10ps
`default_nettype none
module emspm_mapper
  import emspm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        delay_chain_test_trigger,
  input  wire logic [9:0]  delay_chain_probe_bits,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_mem_cycle,
  output logic [24:0]      mapped_addr,
  output logic             mapped_hit,
  output logic             ems_chip_select,
  output logic [7:0]       shared_low_address_data_bus,
  output logic             shared_low_address_data_bus_oe
);

  // Mapping registers and their next values
  logic [15:0] map_q [NUM_REGS];
  logic [15:0] map_d [NUM_REGS];
  // Pointer and control registers
  logic [5:0]  ptr_q;
  logic [5:0]  ptr_d;
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  // Write channel holding registers
  logic [17:0] awa_q;
  logic [17:0] awa_d;
  logic [31:0] wd_q;
  logic [31:0] wd_d;
  logic [3:0]  ws_q;
  logic [3:0]  ws_d;
  logic        awf_q;
  logic        awf_d;
  logic        wf_q;
  logic        wf_d;
  // Response registers
  logic        bv_q;
  logic        bv_d;
  logic [1:0]  br_q;
  logic [1:0]  br_d;
  logic        rv_q;
  logic        rv_d;
  logic [1:0]  rr_q;
  logic [1:0]  rr_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  // Translation output registers
  logic [24:0] ma_q;
  logic [24:0] ma_d;
  logic        hit_q;
  logic        hit_d;
  logic        cs_q;
  logic        cs_d;
  logic        oe_q;
  logic        oe_d;
  logic [7:0]  bus_q;
  logic [7:0]  bus_d;
  // Decode helpers
  logic        wr_go;
  logic        rd_go;
  logic        ptr_ok;
  logic [15:0] cur;
  logic [5:0]  sel;
  logic        sel_ok;

  assign s_axi_awready = !awf_q && !bv_q;
  assign s_axi_wready  = !wf_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rd_q;
  assign mapped_addr   = ma_q;
  assign mapped_hit    = hit_q;
  assign ems_chip_select = cs_q;
  assign shared_low_address_data_bus    = bus_q;
  assign shared_low_address_data_bus_oe = oe_q;

  assign wr_go  = awf_q && wf_q && !bv_q;
  assign rd_go  = s_axi_arvalid && !rv_q;
  assign ptr_ok = ptr_q <= LAST_REG;
  assign cur    = ptr_ok ? map_q[ptr_q] : 16'h0000;

  // Bus slave, pointer, control and mapping registers
  always_comb begin
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    awf_d = awf_q;
    wf_d  = wf_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rr_d  = rr_q;
    rd_d  = rd_q;
    ptr_d = ptr_q;
    ctl_d = ctl_q;
    map_d = map_q;
    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      awa_d = s_axi_awaddr;
      awf_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      wf_d = 1'b1;
    end
    // Both halves held: perform the write and raise the response
    if (wr_go) begin
      awf_d = 1'b0;
      wf_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = RESP_OKAY;
      case (awa_q)
        ADDR_POINTER: begin
          if (ws_q[0]) ptr_d = wd_q[5:0];
        end
        ADDR_CONTROL: begin
          for (int b = 0; b < 16; b++) begin
            if (ws_q[b/8] && CONTROL_MASK[b]) ctl_d[b] = wd_q[b];
          end
        end
        ADDR_DATA: begin
          // Programming is refused while the unit is off
          if (ptr_ok && ctl_q[GROUP_LSB +: 2] != GRP_OFF) begin
            for (int b = 0; b < 16; b++) begin
              if (ws_q[b/8] && REG_MASK[b]) map_d[ptr_q][b] = wd_q[b];
            end
          end
          if (ctl_q[STEP_BIT]) ptr_d = ptr_q + 6'h01;
        end
        default: br_d = RESP_SLVERR;
      endcase
    end
    // Responses stand until the master takes them
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    // Read answer is registered; a stepping data read also moves the pointer
    if (rd_go) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_POINTER: rd_d[15:0] = {delay_chain_test_trigger ? delay_chain_probe_bits
                                    : 10'h000, ptr_q};
        ADDR_CONTROL: rd_d[15:0] = ctl_q;
        ADDR_DATA: begin
          rd_d[15:0] = cur & REG_MASK;
          if (ctl_q[STEP_BIT]) ptr_d = ptr_q + 6'h01;
        end
        default: rr_d = RESP_SLVERR;
      endcase
    end
  end

  // Window decode: which register, if any, owns the address
  always_comb begin
    logic [23:0] ubase;
    ubase  = UPPER_FIRST + (WIN_SIZE * 24'(ctl_q[BASE_LSB +: 2]));
    sel    = 6'h00;
    sel_ok = 1'b0;
    if (cpu_addr >= ubase && cpu_addr < ubase + (WIN_SIZE * 24'h8)
        && ctl_q[GROUP_LSB + 1]) begin
      sel    = UPPER_BASE + {3'b000, cpu_addr[16:14]};
      // Off-board pages must keep enable clear, yet still need the select
      sel_ok = map_q[sel][EN_BIT] || map_q[sel][OFFB_BIT];
    end else if (ctl_q[GROUP_LSB +: 2] == GRP_BOTH) begin
      // Window number equals register number from 128K up to 512K
      if (cpu_addr >= LOWER_START && cpu_addr < LOWER_SPLIT) begin
        sel    = cpu_addr[19:14];
        sel_ok = 1'b1;
      end else if (cpu_addr >= LOWER_SPLIT && cpu_addr < LOWER_END) begin
        sel    = {3'b000, cpu_addr[16:14]};
        sel_ok = 1'b1;
      end
    end
  end

  // Translation outputs, registered each cycle
  always_comb begin
    logic [15:0] ent;
    ent   = map_q[sel];
    ma_d  = {1'b0, cpu_addr};
    hit_d = 1'b0;
    cs_d  = 1'b0;
    oe_d  = 1'b0;
    bus_d = 8'h00;
    if (cpu_mem_cycle && sel_ok) begin
      // Off-board page: card takes the low page bits, no on-board hit
      if (ent[OFFB_BIT]) begin
        cs_d  = 1'b1;
        oe_d  = 1'b1;
        bus_d = ent[7:0];
      end else begin
        hit_d = 1'b1;
        ma_d  = {ent[10:0], cpu_addr[PAGE_LSB-1:0]};
      end
    end
  end

  // Register stage; only registers 32..39 get reset values
  // Registers 0..31 stay unset, so software must load them before use
  always_ff @(posedge aclk) begin
    map_q <= map_d;
    if (!aresetn) begin
      for (int i = int'(UPPER_BASE); i < NUM_REGS; i++) begin
        map_q[i] <= 16'h0000;
      end
      ptr_q <= 6'h00;
      ctl_q <= 16'h0000;
      awa_q <= '0;
      wd_q  <= '0;
      ws_q  <= '0;
      awf_q <= 1'b0;
      wf_q  <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= RESP_OKAY;
      rv_q  <= 1'b0;
      rr_q  <= RESP_OKAY;
      rd_q  <= '0;
      ma_q  <= '0;
      hit_q <= 1'b0;
      cs_q  <= 1'b0;
      oe_q  <= 1'b0;
      bus_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
      ctl_q <= ctl_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      awf_q <= awf_d;
      wf_q  <= wf_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      rv_q  <= rv_d;
      rr_q  <= rr_d;
      rd_q  <= rd_d;
      ma_q  <= ma_d;
      hit_q <= hit_d;
      cs_q  <= cs_d;
      oe_q  <= oe_d;
      bus_q <= bus_d;
    end
  end

endmodule : emspm_mapper
`default_nettype wire

// file: core/emspm_pkg.sv
// Package of constants for the expanded-memory page mapper.
// Assumes an AXI4-Lite register bus with 32-bit data and a 24-bit processor address.
package emspm_pkg;
  localparam int unsigned NUM_REGS   = 40;
  localparam logic [5:0]  UPPER_BASE = 6'h20;
  localparam logic [5:0]  LAST_REG   = 6'h27;
  localparam logic [15:0] REG_MASK   = 16'h8FFF;
  localparam int unsigned EN_BIT     = 15;
  localparam int unsigned OFFB_BIT   = 11;
  localparam int unsigned PAGE_LSB   = 14;
  // Register indices; offsets are not word multiples, so byte address is four times index
  localparam logic [15:0] IDX_POINTER = 16'hE072;
  localparam logic [15:0] IDX_DATA    = 16'hE872;
  localparam logic [15:0] IDX_CONTROL = 16'h6872;
  localparam logic [17:0] ADDR_POINTER = {IDX_POINTER, 2'b00};
  localparam logic [17:0] ADDR_DATA    = {IDX_DATA, 2'b00};
  localparam logic [17:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [15:0] CONTROL_MASK = 16'hECFF;
  localparam int unsigned STEP_BIT   = 15;
  localparam int unsigned BASE_LSB   = 13;
  localparam int unsigned GROUP_LSB  = 10;
  localparam logic [1:0]  GRP_OFF    = 2'b00;
  localparam logic [1:0]  GRP_BOTH   = 2'b11;
  localparam logic [23:0] UPPER_FIRST = 24'h0C4000;
  localparam logic [23:0] WIN_SIZE    = 24'h004000;
  localparam logic [23:0] LOWER_START = 24'h020000;
  localparam logic [23:0] LOWER_SPLIT = 24'h080000;
  localparam logic [23:0] LOWER_END   = 24'h0A0000;
  localparam logic [5:0]  LOW_SHIFT   = 6'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : emspm_pkg

// file: tb/emspm_cpu_model.sv
// Processor model issuing one-cycle memory accesses.
// Assumes the bench pulses go for one clock.
`timescale 1ns/10ps
`default_nettype none
module emspm_cpu_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic [23:0] req,
  output logic [23:0]      cpu_addr,
  output logic             cpu_mem_cycle
);
  // Idle address inverts so a stale value never looks valid
  always_ff @(posedge aclk) begin
    cpu_mem_cycle <= go & aresetn;
    cpu_addr      <= !aresetn ? 24'h000000 : go ? req : ~cpu_addr;
  end
endmodule : emspm_cpu_model
`default_nettype wire

// file: tb/emspm_monitor.sv
// Port checker for the page mapper.
// Assumes it is bound into emspm_mapper.
`timescale 1ns/10ps
`default_nettype none
module emspm_monitor
  import emspm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [23:0] cpu_addr,
  input wire logic        cpu_mem_cycle,
  input wire logic [24:0] mapped_addr,
  input wire logic        mapped_hit,
  input wire logic        ems_chip_select,
  input wire logic        shared_low_address_data_bus_oe
);
  logic [23:0] a_q;
  logic        c_q;
  logic        r_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last cycle's inputs, since translation lags by one clock
  always_ff @(posedge aclk) begin
    a_q <= cpu_addr;
    c_q <= cpu_mem_cycle;
    r_q <= aresetn;
  end
  a_cs_drives_bus: assert property (
    ems_chip_select |-> shared_low_address_data_bus_oe && !mapped_hit) else $error("bad select");
  a_hit_needs_cycle: assert property (
    mapped_hit || ems_chip_select |-> c_q) else $error("output without cycle");
  a_miss_passes: assert property (
    r_q && !mapped_hit && !ems_chip_select |-> mapped_addr == {1'b0, a_q})
    else $error("miss altered address");
  a_hit_window: assert property (
    mapped_hit |-> (a_q >= LOWER_START && a_q < LOWER_END)
      || (a_q >= UPPER_FIRST && a_q < 24'h0F0000)) else $error("hit outside frames");
  a_low_bits: assert property (
    mapped_hit |-> mapped_addr[13:0] == a_q[13:0]) else $error("offset lost");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  a_ar_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_rvalid_ends: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  c_hit: cover property (mapped_hit);
  c_offboard: cover property (ems_chip_select);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : emspm_monitor
`default_nettype wire

// file: tb/tb_emspm_mapper.sv
// Bench for the page mapper: register traffic and translation.
// Assumes package, mapper, model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_emspm_mapper
  import emspm_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, delay_chain_test_trigger = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0]  delay_chain_probe_bits = 10'h2A5;
  logic [23:0] cpu_addr, a, req = 24'h000000;
  logic        cpu_mem_cycle, mapped_hit, ems_chip_select, shared_low_address_data_bus_oe;
  logic [24:0] mapped_addr;
  logic [7:0]  shared_low_address_data_bus;
  logic [15:0] rd;
  logic [9:0]  side;
  int          errors = 0, n_compared = 0, ticks = 0;
  emspm_mapper emspm_mapper_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .delay_chain_test_trigger(delay_chain_test_trigger),
    .delay_chain_probe_bits(delay_chain_probe_bits),
    .cpu_addr(cpu_addr), .cpu_mem_cycle(cpu_mem_cycle),
    .mapped_addr(mapped_addr), .mapped_hit(mapped_hit), .ems_chip_select(ems_chip_select),
    .shared_low_address_data_bus(shared_low_address_data_bus),
    .shared_low_address_data_bus_oe(shared_low_address_data_bus_oe)
  );
  emspm_cpu_model emspm_cpu_model_i (
    .aclk(aclk), .aresetn(aresetn), .go(go), .req(req),
    .cpu_addr(cpu_addr), .cpu_mem_cycle(cpu_mem_cycle)
  );
  always #2 aclk = ~aclk;
  // Ceiling far above the few hundred cycles needed
  always @(posedge aclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [17:0] ad, input logic [15:0] d);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask : wr
  task automatic rdx(input logic [17:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata[15:0];
    rs = s_axi_rresp;
  endtask : rdx
  task automatic rc(input logic [17:0] ad, input logic [15:0] e);
    rdx(ad);
    chk({14'h0000, rs, rd}, {14'h0000, RESP_OKAY, e});
  endtask : rc
  task automatic mem(input logic [23:0] ad, input logic [24:0] e, input logic h);
    req <= ad;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    // Model presents the access here; mapper registers it one edge later
    @(posedge aclk);
    @(negedge aclk);
    side = {ems_chip_select, shared_low_address_data_bus_oe, shared_low_address_data_bus};
    chk({6'h00, mapped_hit, mapped_addr}, {6'h00, h, e});
    @(posedge aclk);
  endtask : mem
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(ADDR_POINTER, 16'h0020);
    rc(ADDR_DATA, 16'h0000);
    rc(ADDR_CONTROL, 16'h0000);
    wr(ADDR_CONTROL, 16'h8800);
    for (int i = 0; i < 8; i++) wr(ADDR_DATA, 16'hF040 + i[15:0]);
    rc(ADDR_POINTER, 16'h0028);
    wr(ADDR_POINTER, 16'h0020);
    for (int i = 0; i < 8; i++) rc(ADDR_DATA, 16'h8040 + i[15:0]);
    $display("registers done");
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_CONTROL, 16'h0800 | 16'(b << 13));
      for (int w = 0; w < 8; w++) begin
        a = UPPER_FIRST + 24'((b + w) * 'h4000) + 24'h000123;
        mem(a, {11'h040 + {8'h00, a[16:14]}, a[13:0]}, 1'b1);
      end
      a = 24'h0C0000 + 24'(b * 'h4000);
      mem(a, {1'b0, a}, 1'b0);
    end
    $display("upper frame done");
    wr(ADDR_CONTROL, 16'h0800);
    wr(ADDR_POINTER, 16'h0021);
    wr(ADDR_DATA, 16'h0040);
    mem(24'h0C4000, 25'h00C4000, 1'b0);
    wr(ADDR_POINTER, 16'h0022);
    wr(ADDR_DATA, 16'h0812);
    mem(24'h0C8010, 25'h00C8010, 1'b0);
    chk({22'h0, side}, 32'h00000312);
    $display("enable and off-board done");
    wr(ADDR_CONTROL, 16'h8C00);
    wr(ADDR_POINTER, 16'h0000);
    for (int i = 0; i < 32; i++) wr(ADDR_DATA, 16'h0100 + i[15:0]);
    for (int w = 0; w < 32; w++) begin
      a = LOWER_START + 24'(w * 'h4000) + 24'h003FFF;
      mem(a, {11'h100 + 11'((w + 8) % 32), a[13:0]}, 1'b1);
    end
    wr(ADDR_CONTROL, 16'h0800);
    mem(24'h020000, 25'h0020000, 1'b0);
    wr(ADDR_CONTROL, 16'h0000);
    mem(24'h0E0000, 25'h00E0000, 1'b0);
    wr(ADDR_POINTER, 16'h0020);
    wr(ADDR_DATA, 16'h1234);
    wr(ADDR_CONTROL, 16'h0400);
    rc(ADDR_DATA, 16'h8040);
    $display("lower frame and groups done");
    delay_chain_test_trigger <= 1'b1;
    rc(ADDR_POINTER, 16'hA960);
    delay_chain_test_trigger <= 1'b0;
    rdx(18'h00000);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("probes and decode done");
    close_out();
  end
endmodule : tb_emspm_mapper
bind emspm_mapper emspm_monitor emspm_monitor_i (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cpu_addr(cpu_addr), .cpu_mem_cycle(cpu_mem_cycle),
  .mapped_addr(mapped_addr), .mapped_hit(mapped_hit), .ems_chip_select(ems_chip_select),
  .shared_low_address_data_bus_oe(shared_low_address_data_bus_oe)
);
`default_nettype wire
